/* rtl/relay_consts.svh */
// relay output block constants: offsets, field layout, codes, timing
// assumes inclusion by the package and the modules of the relay block
// Overview of operation
// - three relays, each one selected function, working only with aux power
// - mechanical trip relay follows open mechanism with current present
// - mechanical alarm relay follows coil fault or open mechanism with current
// - electrical alarm relay follows OR of four internal fault flags
// - over/under voltage trip and alarm close when enabled and occurred
// - over/under frequency trip and alarm close when enabled and occurred
// - voltage/current unbalance trip and alarm close when enabled and occurred
// - reverse power, sequence, loss, demand close when enabled and occurred
// - event relays stay closed until button, communications or register reset
// - two AC inputs sampled into status readable over register port
// - serial port only answers master requests, never initiates
// - address 1..247, four baud rates, parity, stop bits, defaults
// - function codes 02 03 04 06 08 16 served, others refused
// - at most 122 registers per transaction, zero or larger counts refused
`ifndef RELAY_CONSTS_SVH
`define RELAY_CONSTS_SVH

`define N_RELAY          3
`define N_LATCH          20
`define N_AC             2
`define SEL_W            5

// relay function selections
`define SEL_OFF          5'h00
`define SEL_MECH_TRIP    5'h01
`define SEL_MECH_ALARM   5'h02
`define SEL_ELEC_ALARM   5'h03
`define SEL_LATCH_BASE   5'h04
`define SEL_LATCH_LAST   5'h17

// register byte offsets
`define A_CTRL           8'h00
`define A_SEL            8'h04
`define A_ENABLE         8'h08
`define A_STATUS         8'h0c
`define A_LATCH          8'h10
`define A_PORT           8'h14
`define A_INT_STAT       8'h18
`define A_INT_MASK       8'h1c

// field positions
`define CTRL_RESET_BIT   0
`define ST_AC_LSB        3
`define ST_AUX_BIT       5
`define PORT_BAUD_LSB    8
`define PORT_PAR_LSB     10
`define PORT_STOP_BIT    12
`define INT_LATCH_BIT    0
`define INT_AC_BIT       1
`define INT_REFUSED_BIT  2
`define INT_W            3

// serial port settings
`define ADDR_MIN         8'h01
`define ADDR_MAX         8'hf7
`define ADDR_DEF         8'h01
`define BAUD_DEF         2'h0
`define PAR_EVEN         2'h0
`define PAR_ODD          2'h1
`define PAR_NONE         2'h2
`define STOP_ONE         1'h0
`define CLK_HZ           100000000
`define BAUD_RATE0       9600
`define BAUD_RATE1       19200
`define BAUD_RATE2       38400
`define BAUD_RATE3       57600

// request codes and limits
`define FC_READ_INPUTS   8'h02
`define FC_READ_HOLD     8'h03
`define FC_READ_IN_REG   8'h04
`define FC_WRITE_SINGLE  8'h06
`define FC_DIAG          8'h08
`define FC_WRITE_MULTI   8'h10
`define QTY_MAX          8'h7a
`define EXC_FUNC         8'h01
`define EXC_VALUE        8'h03

`endif

/* rtl/relay_pkg.sv */
// relay output block types and shared decode functions
// assumes the constants header sits beside it
`include "relay_consts.svh"
package relay_pkg;

   typedef logic [`SEL_W-1:0] relay_sel_t;

   typedef enum logic [2:0]
   {
      ST_IDLE   = 3'b001,
      ST_CHECK  = 3'b010,
      ST_ANSWER = 3'b100
   } req_state_e;

   typedef struct packed
   {
      logic coil_fault;
      logic mech_open;
      logic current_on;
      logic cfg_read_err;
      logic clock_fault;
      logic wdog_fault;
      logic health_alarm;
   } live_fault_s;

   typedef struct packed
   {
      logic       stop;
      logic [1:0] parity;
      logic [1:0] baud;
      logic [7:0] addr;
   } port_cfg_s;

   typedef struct packed
   {
      logic [7:0] addr;
      logic [7:0] func;
      logic [7:0] qty;
   } mb_req_s;

   typedef struct packed
   {
      logic       exc;
      logic [7:0] code;
      logic [7:0] func;
      logic [7:0] qty;
   } mb_rsp_s;

   // served request codes
   function automatic logic fc_supported(input logic [7:0] fc);
      case (fc)
         `FC_READ_INPUTS, `FC_READ_HOLD, `FC_READ_IN_REG,
         `FC_WRITE_SINGLE, `FC_DIAG, `FC_WRITE_MULTI:
            fc_supported = 1'b1;
         default:
            fc_supported = 1'b0;
      endcase
   endfunction

   // codes that carry a register count
   function automatic logic fc_counted(input logic [7:0] fc);
      fc_counted = (fc == `FC_READ_HOLD) || (fc == `FC_READ_IN_REG) ||
                   (fc == `FC_WRITE_MULTI);
   endfunction

endpackage

/* rtl/relay_channel.sv */
// one relay output: function select and contact drive
// assumes latched events and live faults come from the top
`timescale 1ns/100ps
`include "relay_consts.svh"
module relay_channel
(
   input  wire logic                   mclk_i,
   input  wire logic                   rst_i,
   input  wire relay_pkg::relay_sel_t  sel_i,
   input  wire relay_pkg::live_fault_s live_i,
   input  wire logic [`N_LATCH-1:0]    latch_i,
   input  wire logic                   aux_power_i,
   output      logic                   close_o
);
   logic                   nxt_close;
   relay_pkg::relay_sel_t  idx;

   // function select
   always_comb
   begin
      idx = sel_i - `SEL_LATCH_BASE;
      case (sel_i)
         `SEL_OFF:        nxt_close = 1'b0;
         `SEL_MECH_TRIP:  nxt_close = live_i.mech_open & live_i.current_on;
         `SEL_MECH_ALARM: nxt_close = live_i.coil_fault |
                                      (live_i.mech_open & live_i.current_on);
         `SEL_ELEC_ALARM: nxt_close = live_i.cfg_read_err |
                                      live_i.clock_fault |
                                      live_i.wdog_fault | live_i.health_alarm;
         default:
            nxt_close = (sel_i <= `SEL_LATCH_LAST) ? latch_i[idx] : 1'b0;
      endcase
   end

   // contact drive
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
         close_o <= 1'b0;
      else
         close_o <= nxt_close & aux_power_i;
   end
endmodule

/* rtl/mb_request_check.sv */
// serial request screening: address match, code and count checks
// assumes framing logic outside hands over decoded requests
`timescale 1ns/100ps
`include "relay_consts.svh"
module mb_request_check
(
   input  wire logic                 mclk_i,
   input  wire logic                 rst_i,
   input  wire relay_pkg::port_cfg_s cfg_i,
   input  wire logic                 req_valid_i,
   input  wire relay_pkg::mb_req_s   req_i,
   output      logic                 rsp_valid_o,
   output      relay_pkg::mb_rsp_s   rsp_o
);
   relay_pkg::req_state_e state_ff;
   relay_pkg::mb_req_s    req_ff;
   logic                  qty_bad;

   assign qty_bad = relay_pkg::fc_counted(req_ff.func) &&
                    ((req_ff.qty == 8'h00) || (req_ff.qty > `QTY_MAX));

   // sequencing, new requests ignored while busy
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
         state_ff <= relay_pkg::ST_IDLE;
      else
         case (state_ff)
            relay_pkg::ST_IDLE:
               if (req_valid_i)
                  state_ff <= relay_pkg::ST_CHECK;
            relay_pkg::ST_CHECK:  state_ff <= relay_pkg::ST_ANSWER;
            default:              state_ff <= relay_pkg::ST_IDLE;
         endcase
   end

   // request capture
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
         req_ff <= '0;
      else if (state_ff == relay_pkg::ST_IDLE && req_valid_i)
         req_ff <= req_i;
   end

   // answer build
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         rsp_valid_o <= 1'b0;
         rsp_o       <= '0;
      end
      else
      begin
         rsp_valid_o <= (state_ff == relay_pkg::ST_CHECK) &&
                        (req_ff.addr == cfg_i.addr);
         if (state_ff == relay_pkg::ST_CHECK)
         begin
            rsp_o.func <= req_ff.func;
            rsp_o.qty  <= req_ff.qty;
            if (!relay_pkg::fc_supported(req_ff.func))
            begin
               rsp_o.exc  <= 1'b1;
               rsp_o.code <= `EXC_FUNC;
            end
            else if (qty_bad)
            begin
               rsp_o.exc  <= 1'b1;
               rsp_o.code <= `EXC_VALUE;
            end
            else
            begin
               rsp_o.exc  <= 1'b0;
               rsp_o.code <= 8'h00;
            end
         end
      end
   end
endmodule

/* rtl/relay_output_top.sv */
// relay output block top: register port, event latches, relays,
// AC input status, serial port settings, interrupt
// assumes one 100 MHz clock, sync reset, requests already deframed
`timescale 1ns/100ps
`include "relay_consts.svh"
module relay_output_top
(
   input  wire logic                   mclk_i,
   input  wire logic                   rst_i,
   input  wire logic [7:0]             addr_i,
   input  wire logic [31:0]            wdata_i,
   input  wire logic                   wr_i,
   input  wire logic                   rd_i,
   output      logic [31:0]            rdata_o,
   input  wire logic                   aux_power_i,
   input  wire logic                   reset_button_i,
   input  wire logic                   comm_reset_i,
   input  wire relay_pkg::live_fault_s live_i,
   input  wire logic [`N_LATCH-1:0]    event_i,
   input  wire logic [`N_AC-1:0]       external_ac_input_i,
   input  wire logic                   req_valid_i,
   input  wire relay_pkg::mb_req_s     req_i,
   output      logic                   rsp_valid_o,
   output      relay_pkg::mb_rsp_s     rsp_o,
   output      relay_pkg::port_cfg_s   port_cfg_o,
   output      logic [15:0]            bit_div_o,
   output      logic [`N_RELAY-1:0]    relay_o,
   output      logic [`N_AC-1:0]       ac_status_o,
   output      logic                   irq_o
);

   ////////////////////////////////////////////////////////////////////
   // declarations
   logic [`N_RELAY*`SEL_W-1:0] sel_ff;
   logic [`N_LATCH-1:0]        enable_ff;
   logic [`N_LATCH-1:0]        latch_ff;
   logic [`N_LATCH-1:0]        hit_set;
   relay_pkg::port_cfg_s       port_ff;
   logic [`N_AC-1:0]           ac_ff;
   logic [`INT_W-1:0]          int_stat_ff;
   logic [`INT_W-1:0]          int_mask_ff;
   logic [`INT_W-1:0]          int_event;
   logic [31:0]                rdata_ff;
   logic [31:0]                nxt_rdata;
   logic [15:0]                bit_div_ff;
   logic                       clr;
   logic                       wr_ctrl;
   logic                       wr_port;
   logic [7:0]                 new_addr;
   logic [1:0]                 new_par;

   ////////////////////////////////////////////////////////////////////
   // functions

   // strobe plus address match
   function automatic logic bus_hit(input logic       stb,
                                    input logic [7:0] a,
                                    input logic [7:0] off);
      bus_hit = stb && (a == off);
   endfunction

   // bit period in clock cycles for a baud selection
   function automatic logic [15:0] baud_div(input logic [1:0] b);
      case (b)
         2'h0:    baud_div = 16'(`CLK_HZ / `BAUD_RATE0);
         2'h1:    baud_div = 16'(`CLK_HZ / `BAUD_RATE1);
         2'h2:    baud_div = 16'(`CLK_HZ / `BAUD_RATE2);
         default: baud_div = 16'(`CLK_HZ / `BAUD_RATE3);
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////
   // decode and reset request
   assign wr_ctrl  = bus_hit(wr_i, addr_i, `A_CTRL);
   assign wr_port  = bus_hit(wr_i, addr_i, `A_PORT);
   assign new_addr = wdata_i[7:0];
   assign new_par  = wdata_i[`PORT_PAR_LSB +: 2];
   assign clr      = reset_button_i | comm_reset_i |
                     (wr_ctrl & wdata_i[`CTRL_RESET_BIT]);
   assign hit_set  = enable_ff & event_i;

   ////////////////////////////////////////////////////////////////////
   // relay selection and function enables
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         sel_ff    <= '0;
         enable_ff <= '0;
      end
      else
      begin
         if (bus_hit(wr_i, addr_i, `A_SEL))
            sel_ff <= wdata_i[`N_RELAY*`SEL_W-1:0];
         if (bus_hit(wr_i, addr_i, `A_ENABLE))
            enable_ff <= wdata_i[`N_LATCH-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // event latches, set beats clear
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
         latch_ff <= '0;
      else
         latch_ff <= (latch_ff & {`N_LATCH{~clr}}) | hit_set;
   end

   ////////////////////////////////////////////////////////////////////
   // relay outputs
   genvar gi;
   generate
      for (gi = 0; gi < `N_RELAY; gi++)
      begin : g_relay
         relay_channel u_chan
         (
            .mclk_i      (mclk_i),
            .rst_i       (rst_i),
            .sel_i       (sel_ff[gi*`SEL_W +: `SEL_W]),
            .live_i      (live_i),
            .latch_i     (latch_ff),
            .aux_power_i (aux_power_i),
            .close_o     (relay_o[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // AC input status
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
         ac_ff <= '0;
      else
         ac_ff <= external_ac_input_i;
   end
   assign ac_status_o = ac_ff;

   ////////////////////////////////////////////////////////////////////
   // serial port settings, bad field values keep old setting
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         port_ff.addr   <= `ADDR_DEF;
         port_ff.baud   <= `BAUD_DEF;
         port_ff.parity <= `PAR_EVEN;
         port_ff.stop   <= `STOP_ONE;
      end
      else if (wr_port)
      begin
         if (new_addr >= `ADDR_MIN && new_addr <= `ADDR_MAX)
            port_ff.addr <= new_addr;
         if (new_par <= `PAR_NONE)
            port_ff.parity <= new_par;
         port_ff.baud <= wdata_i[`PORT_BAUD_LSB +: 2];
         port_ff.stop <= wdata_i[`PORT_STOP_BIT];
      end
   end

   // bit period for the serial framer
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
         bit_div_ff <= baud_div(`BAUD_DEF);
      else
         bit_div_ff <= baud_div(port_ff.baud);
   end
   assign port_cfg_o = port_ff;
   assign bit_div_o  = bit_div_ff;

   ////////////////////////////////////////////////////////////////////
   // request screening
   // slave only answers
   mb_request_check u_check
   (
      .mclk_i      (mclk_i),
      .rst_i       (rst_i),
      .cfg_i       (port_ff),
      .req_valid_i (req_valid_i),
      .req_i       (req_i),
      .rsp_valid_o (rsp_valid_o),
      .rsp_o       (rsp_o)
   );

   ////////////////////////////////////////////////////////////////////
   // interrupt status, mask, read clears, set beats clear
   always_comb
   begin
      int_event                   = '0;
      int_event[`INT_LATCH_BIT]   = |(hit_set & ~latch_ff);
      int_event[`INT_AC_BIT]      = ac_ff != external_ac_input_i;
      int_event[`INT_REFUSED_BIT] = rsp_valid_o & rsp_o.exc;
   end

   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         int_stat_ff <= '0;
         int_mask_ff <= '0;
      end
      else
      begin
         if (bus_hit(rd_i, addr_i, `A_INT_STAT))
            int_stat_ff <= int_event;
         else
            int_stat_ff <= int_stat_ff | int_event;
         if (bus_hit(wr_i, addr_i, `A_INT_MASK))
            int_mask_ff <= wdata_i[`INT_W-1:0];
      end
   end
   assign irq_o = |(int_stat_ff & int_mask_ff);

   ////////////////////////////////////////////////////////////////////
   // read mux, data valid only in the cycle after the strobe
   always_comb
   begin
      nxt_rdata = '0;
      case (addr_i)
         `A_SEL:      nxt_rdata[`N_RELAY*`SEL_W-1:0] = sel_ff;
         `A_ENABLE:   nxt_rdata[`N_LATCH-1:0]        = enable_ff;
         `A_STATUS:
         begin
            nxt_rdata[`N_RELAY-1:0]         = relay_o;
            nxt_rdata[`ST_AC_LSB +: `N_AC]  = ac_ff;
            nxt_rdata[`ST_AUX_BIT]          = aux_power_i;
         end
         `A_LATCH:    nxt_rdata[`N_LATCH-1:0]        = latch_ff;
         `A_PORT:     nxt_rdata[`PORT_STOP_BIT:0]    = port_ff;
         `A_INT_STAT: nxt_rdata[`INT_W-1:0]          = int_stat_ff;
         `A_INT_MASK: nxt_rdata[`INT_W-1:0]          = int_mask_ff;
         default:     nxt_rdata = '0;
      endcase
   end

   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
         rdata_ff <= '0;
      else
         rdata_ff <= rd_i ? nxt_rdata : 32'h0000_0000;
   end
   assign rdata_o = rdata_ff;

   ////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_mech_fault;
      sel_ff[`SEL_W-1:0] == `SEL_MECH_TRIP && aux_power_i &&
      live_i.mech_open && live_i.current_on;
   endsequence

   sequence s_mech_gone;
      sel_ff[`SEL_W-1:0] == `SEL_MECH_TRIP && !live_i.mech_open;
   endsequence

   property p_aux_off;
      !aux_power_i |=> relay_o == '0;
   endproperty
   a_aux_off: assert property (p_aux_off)
      else $error("relay closed without aux power");

   property p_mech_follow;
      s_mech_fault ##1 s_mech_gone |=> !relay_o[0];
   endproperty
   a_mech_follow: assert property (p_mech_follow)
      else $error("mechanical trip relay did not follow fault");

   property p_coil_alarm;
      sel_ff[`SEL_W-1:0] == `SEL_MECH_ALARM && aux_power_i &&
      live_i.coil_fault |=> relay_o[0];
   endproperty
   a_coil_alarm: assert property (p_coil_alarm)
      else $error("coil fault did not close alarm relay");

   property p_elec_alarm;
      sel_ff[`SEL_W-1:0] == `SEL_ELEC_ALARM && aux_power_i &&
      live_i.clock_fault |=> relay_o[0];
   endproperty
   a_elec_alarm: assert property (p_elec_alarm)
      else $error("electrical fault did not close relay");

   property p_latch_set;
      hit_set != '0 |=> (latch_ff & $past(hit_set)) == $past(hit_set);
   endproperty
   a_latch_set: assert property (p_latch_set)
      else $error("enabled event not latched");

   property p_unenabled;
      (enable_ff == '0 && latch_ff == '0) |=> latch_ff == '0;
   endproperty
   a_unenabled: assert property (p_unenabled)
      else $error("latch set with no function enabled");

   property p_latch_hold;
      !clr |=> (latch_ff & $past(latch_ff)) == $past(latch_ff);
   endproperty
   a_latch_hold: assert property (p_latch_hold)
      else $error("latched function dropped without reset");

   property p_off_relay;
      sel_ff[`SEL_W-1:0] == `SEL_OFF |=> !relay_o[0];
   endproperty
   a_off_relay: assert property (p_off_relay)
      else $error("disabled relay closed");

   property p_clear_all;
      clr && hit_set == '0 |=> latch_ff == '0;
   endproperty
   a_clear_all: assert property (p_clear_all)
      else $error("reset did not clear all latches");

   property p_ac_status;
      1'b1 |=> ac_status_o == $past(external_ac_input_i);
   endproperty
   a_ac_status: assert property (p_ac_status)
      else $error("AC input status not updated");

   property p_no_initiate;
      rsp_valid_o |-> $past(req_valid_i, 2) && !$past(rsp_valid_o);
   endproperty
   a_no_initiate: assert property (p_no_initiate)
      else $error("answer without a request");

   property p_port_range;
      port_ff.addr >= `ADDR_MIN && port_ff.addr <= `ADDR_MAX &&
      port_ff.parity <= `PAR_NONE;
   endproperty
   a_port_range: assert property (p_port_range)
      else $error("serial setting out of range");

   property p_bad_code;
      rsp_valid_o && !relay_pkg::fc_supported(rsp_o.func) |->
      rsp_o.exc && rsp_o.code == `EXC_FUNC;
   endproperty
   a_bad_code: assert property (p_bad_code)
      else $error("unsupported code not refused");

   property p_qty_limit;
      rsp_valid_o && relay_pkg::fc_supported(rsp_o.func) &&
      relay_pkg::fc_counted(rsp_o.func) && rsp_o.qty > `QTY_MAX |->
      rsp_o.exc && rsp_o.code == `EXC_VALUE;
   endproperty
   a_qty_limit: assert property (p_qty_limit)
      else $error("oversized transaction not refused");

endmodule

/* tb/mb_master_model.sv */
// serial master stand-in issuing decoded requests
// assumes the bench spaces its sends at least three cycles apart
`timescale 1ns/100ps
`include "relay_consts.svh"
module mb_master_model
(
   input  wire logic               mclk_i,
   input  wire logic               send_i,
   input  wire logic               over_i,
   input  wire relay_pkg::mb_req_s cmd_i,
   output      logic               req_valid_o,
   output      relay_pkg::mb_req_s req_o
);
   initial req_o = '0;
   // sends on command only, count capped unless over_i is set
   always @(posedge mclk_i)
   begin
      req_valid_o <= send_i;
      // one assignment per edge: capped count or command or idle
      if (send_i && !over_i && cmd_i.qty > `QTY_MAX)
         req_o <= {cmd_i.addr, cmd_i.func, `QTY_MAX};
      else
         req_o <= send_i ? cmd_i : ~req_o; // idle lines show inverse
   end
endmodule

/* tb/relay_output_top_tb.sv */
// self-checking bench for the relay output block
// assumes the master stand-in drives the request side
`timescale 1ns/100ps
`include "relay_consts.svh"
module relay_output_top_tb;
   logic mclk_i, rst_i, wr_i, rd_i, aux_power_i, reset_button_i;
   logic comm_reset_i, send, ovr, req_valid_i, rsp_valid_o, irq_o, rd_seen;
   logic [7:0] addr_i, own;
   logic [31:0] wdata_i, rdata_o;
   logic [`N_LATCH-1:0] event_i;
   logic [`N_AC-1:0] external_ac_input_i, ac_status_o;
   logic [15:0] bit_div_o;
   logic [`N_RELAY-1:0] relay_o;
   relay_pkg::live_fault_s live_i;
   relay_pkg::mb_req_s req_i, cmd;
   relay_pkg::mb_rsp_s rsp_o, sq[$];
   relay_pkg::port_cfg_s port_cfg_o;
   logic [31:0] rq[$];
   logic [12:0] lc[13] = '{13'h10b0, 13'h0090, 13'h00c0, 13'h1140,
      13'h1130, 13'h010f, 13'h1188, 13'h1184, 13'h1182, 13'h1181,
      13'h01f0, 13'h007f, 13'h0c7f}; // expect, select, live faults
   logic [7:0] fc[6] = '{8'h02, 8'h03, 8'h04, 8'h06, 8'h08, 8'h10};
   int mismatches = 0, num_checks = 0, cycles = 0, seed, k;

   relay_output_top relay_output_top_inst
   (
      .mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .aux_power_i(aux_power_i), .reset_button_i(reset_button_i),
      .comm_reset_i(comm_reset_i), .live_i(live_i), .event_i(event_i),
      .external_ac_input_i(external_ac_input_i), .req_valid_i(req_valid_i),
      .req_i(req_i), .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o),
      .port_cfg_o(port_cfg_o), .bit_div_o(bit_div_o), .relay_o(relay_o),
      .ac_status_o(ac_status_o), .irq_o(irq_o)
   );
   mb_master_model mb_master_model_inst
   (
      .mclk_i(mclk_i), .send_i(send), .over_i(ovr), .cmd_i(cmd),
      .req_valid_o(req_valid_i), .req_o(req_i)
   );
   ////////////////////////////////////////////////////////////////////////
   // clock and hang guard
   initial
   begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end
   always @(posedge mclk_i)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         mismatches++;
         complete_run();
      end
   end
   task automatic chk(input string n, input logic [31:0] e, s);
      num_checks++;
      if (s !== e)
      begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // watcher: oldest note against each read or answer
   always @(posedge mclk_i) rd_seen <= rd_i;
   always @(negedge mclk_i)
   begin
      if (rd_seen === 1'b1)
         chk("rdata", rq.pop_front(), rdata_o);
      if (rsp_valid_o !== 1'b0)
         chk("answer", sq.size() ? {7'h0, sq.pop_front()} : '1, rsp_o);
   end
   // register bus cycles and request sends
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      {addr_i, wdata_i, wr_i} <= {a, d, 1'b1};
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      rq.push_back(e);
      @(posedge mclk_i);
      {addr_i, rd_i} <= {a, 1'b1};
      @(posedge mclk_i);
      rd_i <= 1'b0;
   endtask
   task automatic req(input logic [7:0] a, f, q, input logic [8:0] ex);
      if (a == own)
         sq.push_back({ex, f, q});
      @(posedge mclk_i);
      {cmd, ovr, send} <= {a, f, q, q > 8'h7a, 1'b1};
      @(posedge mclk_i);
      send <= 1'b0;
      repeat (5) @(posedge mclk_i);
   endtask
   task automatic latch_case(input int k, input logic en);
      int r;
      r = k % 3;
      wr(`A_SEL, 32'(`SEL_LATCH_BASE + k) << (5 * r));
      wr(`A_ENABLE, 32'(en) << k);
      event_i[k] <= 1'b1;
      @(posedge mclk_i);
      event_i[k] <= 1'b0;
      repeat (2) @(negedge mclk_i);
      chk("relay set", 32'(en) << r, relay_o);
      repeat (5) @(negedge mclk_i);
      chk("relay held", 32'(en) << r, relay_o);
      rd(`A_LATCH, 32'(en) << k);
      // three reset sources in turn: communications, button, register
      if (k % 3 == 2)
         wr(`A_CTRL, 32'h1);
      else
      begin
         @(posedge mclk_i);
         {reset_button_i, comm_reset_i} <= (k % 3) ? 2'b10 : 2'b01;
         @(posedge mclk_i);
         {reset_button_i, comm_reset_i} <= 2'b00;
      end
      repeat (2) @(negedge mclk_i);
      chk("relay cleared", 32'h0, relay_o);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      seed = 46684;
      {rst_i, aux_power_i, wr_i, rd_i, reset_button_i, comm_reset_i} = 6'h30;
      {send, ovr, addr_i, wdata_i, live_i, event_i, cmd} = '0;
      {external_ac_input_i, own} = {2'h0, 8'h01};
      repeat (8) @(posedge mclk_i);
      rst_i <= 1'b0;
      rd(`A_PORT, 32'h1);
      chk("bit_div", 32'd10416, bit_div_o);
      for (k = 0; k < 20; k++)
      begin
         latch_case(k, 1'b0);
         latch_case(k, 1'b1);
      end
      wr(`A_INT_MASK, 32'h1);
      @(negedge mclk_i);
      chk("irq", 32'h1, irq_o);
      rd(`A_INT_STAT, 32'h1);
      rd(8'hfc, 32'h0);
      chk("irq", 32'h0, irq_o);
      $display("test latched relays done");
      foreach (lc[i])
      begin
         wr(`A_SEL, 32'(lc[i][11:7]));
         live_i <= lc[i][6:0];
         repeat (2) @(negedge mclk_i);
         chk("live relay", 32'(lc[i][12]), relay_o);
      end
      wr(`A_SEL, 32'h1);
      {live_i, aux_power_i} <= {7'h30, 1'b0};
      repeat (2) @(negedge mclk_i);
      chk("relay no aux", 32'h0, relay_o);
      @(posedge mclk_i);
      {live_i, aux_power_i} <= {7'h0, 1'b1};
      external_ac_input_i <= 2'($random(seed));
      repeat (2) @(negedge mclk_i);
      chk("ac", 32'(external_ac_input_i), ac_status_o);
      rd(`A_STATUS, {27'h1, external_ac_input_i, 3'h0});
      $display("test live relays done");
      for (k = 0; k < 6; k++)
         req(8'h01, fc[k], 8'(1 + {$random(seed)} % 122), 9'h0);
      req(8'h01, 8'h05, 8'h01, 9'h101);
      req(8'h01, 8'h03, 8'h00, 9'h103);
      req(8'h01, 8'h10, 8'h7b, 9'h103);
      req(8'h01, 8'h04, 8'h7a, 9'h000);
      req(8'h00, 8'h03, 8'h01, 9'h000);
      wr(`A_PORT, 32'h17f7);
      own = 8'hf7;
      rd(`A_PORT, 32'h17f7);
      chk("bit_div", 32'd1736, bit_div_o);
      req(8'hf7, 8'h03, 8'h05, 9'h000);
      req(8'h01, 8'h03, 8'h05, 9'h000);
      wr(`A_PORT, 32'h0cf8);
      rd(`A_PORT, 32'h04f7);
      chk("port_cfg", 32'h04f7, 32'(port_cfg_o));
      chk("irq", 32'h0, irq_o);
      wr(`A_INT_MASK, 32'h4);
      @(negedge mclk_i);
      chk("irq", 32'h1, irq_o);
      chk("pending", 32'h0, 32'(sq.size()));
      $display("test serial port done");
      complete_run();
   end
endmodule
